// File: design/scas_pkg.sv
package scas_pkg;

   // ****************************************************************
   // Widths and register map
   // ****************************************************************
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int PW = 12;

   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_EXP = 8'h04;
   localparam logic [AW-1:0] REG_STAT = 8'h08;
   localparam logic [AW-1:0] REG_MEAS = 8'h0C;

   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_RATE_LSB = 1;
   localparam int STAT_IN_LSB = 0;
   localparam int STAT_REF_LSB = 2;
   localparam int STAT_SPD_LSB = 4;
   localparam int STAT_ERR_BIT = 6;
   localparam int STAT_CHG_BIT = 7;

   // ****************************************************************
   // Reset values and cycle counts
   // ****************************************************************
   localparam logic [PW-1:0] EXP_PER_RST = 12'h008;
   localparam logic [PW-1:0] EXP_PER_MIN = 12'h004;
   localparam logic [PW-1:0] PER_TOL = 12'h002;
   localparam logic [PW-1:0] LOSS_CYCLES = 12'h0FF;
   localparam logic [2:0] LOCK_PERIODS = 3'h4;
   localparam logic [2:0] RATE_DS_MIN = 3'h4;
   localparam logic [2:0] RATE_QS_MIN = 3'h6;

   localparam logic [7:0] MASK_8CH = 8'hFF;
   localparam logic [7:0] MASK_4CH = 8'h0F;
   localparam logic [7:0] MASK_2CH = 8'h03;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {IN_NOLOCK, IN_LOCK, IN_SYNC} scas_in_t;
   typedef enum logic [1:0] {REF_INTERNAL, REF_OPTICAL, REF_SPDIF} scas_ref_t;
   typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} scas_speed_t;

   // ****************************************************************
   // Shared decoding
   // ****************************************************************
   function automatic logic within_tol(input logic [PW-1:0] a, input logic [PW-1:0] b);
      logic [PW-1:0] d;
      d = (a >= b) ? a - b : b - a;
      return d <= PER_TOL;
   endfunction : within_tol

   function automatic scas_speed_t speed_of(input logic [2:0] rate);
      if (rate >= RATE_QS_MIN) return SPD_QUAD;
      if (rate >= RATE_DS_MIN) return SPD_DOUBLE;
      return SPD_SINGLE;
   endfunction : speed_of

   function automatic logic [7:0] ch_mask(input scas_speed_t spd);
      logic [7:0] m;
      unique case (spd)
         SPD_DOUBLE: m = MASK_4CH;
         SPD_QUAD: m = MASK_2CH;
         default: m = MASK_8CH;
      endcase
      return m;
   endfunction : ch_mask

endpackage : scas_pkg

// File: design/scas_meas_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scas_meas_if;
   import scas_pkg::*;
   logic edge_p;
   logic period_vld;
   logic [PW-1:0] period;
   logic lock;
   logic spdif;
   modport src (output edge_p, output period_vld, output period, output lock, output spdif);
   modport snk (input edge_p, input period_vld, input period, input lock, input spdif);
endinterface : scas_meas_if
`default_nettype wire

// File: design/scas_link_meas.sv
`timescale 1ns/1ps
`default_nettype none
module scas_link_meas (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic opt_wclk,
   input wire logic opt_spdif_det,
   scas_meas_if.src mo
);
   import scas_pkg::*;

   typedef enum logic {LK_HUNT, LK_LOCKED} scas_lk_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic wclk_d;
      logic edge_p;
      logic period_vld;
      logic [PW-1:0] cnt;
      logic [PW-1:0] period;
      logic [2:0] stab;
      scas_lk_t st;
   } scas_lm_st_t;

   scas_lm_st_t st_r;
   scas_lm_st_t st_nxt;
   logic timeout;
   logic stable;

   assign timeout = (st_r.cnt == LOSS_CYCLES);
   assign stable = within_tol(st_r.cnt, st_r.period);

   // ****************************************************************
   // Edge finding, period measurement and lock hunting
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {opt_spdif_det, opt_wclk};
      st_nxt.s2 = st_r.s1;
      st_nxt.wclk_d = st_r.s2[0];
      st_nxt.edge_p = st_r.s2[0] & ~st_r.wclk_d;
      st_nxt.period_vld = 1'b0;
      if (!timeout) begin
         st_nxt.cnt = st_r.cnt + 12'h001;
      end
      if (st_r.edge_p) begin
         st_nxt.cnt = 12'h001;
         st_nxt.period = st_r.cnt;
         st_nxt.period_vld = 1'b1;
      end
      unique case (st_r.st)
         LK_HUNT: begin
            if (timeout) begin
               st_nxt.stab = 3'h0;
            end else if (st_r.edge_p) begin
               if (!stable) begin
                  st_nxt.stab = 3'h0;
               end else if (st_r.stab == LOCK_PERIODS - 3'h1) begin
                  st_nxt.st = LK_LOCKED;
               end else begin
                  st_nxt.stab = st_r.stab + 3'h1;
               end
            end
         end
         LK_LOCKED: begin
            // A period jump beyond tolerance or a silent link drops lock at once
            if (timeout || (st_r.edge_p && !stable)) begin
               st_nxt.st = LK_HUNT;
               st_nxt.stab = 3'h0;
            end
         end
      endcase
      if (sys_rst) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_r <= st_nxt;
   end

   assign mo.edge_p = st_r.edge_p;
   assign mo.period_vld = st_r.period_vld;
   assign mo.period = st_r.period;
   assign mo.lock = (st_r.st == LK_LOCKED);
   assign mo.spdif = st_r.s2[1];

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_loss_drops_lock: assert property (timeout |=> st_r.st == LK_HUNT)
      else $error("lock held through a silent link");
   a_lock_needs_edges: assert property ($rose(st_r.st == LK_LOCKED) |-> $past(st_r.edge_p))
      else $error("lock gained without a link edge");

endmodule : scas_link_meas
`default_nettype wire

// File: design/scas_top.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module scas_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic opt_wclk,
   input wire logic opt_spdif_det,
   input wire logic [scas_pkg::AW-1:0] reg_addr,
   input wire logic [scas_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [scas_pkg::DW-1:0] reg_rdata,
   output logic smp_tick,
   output var scas_pkg::scas_ref_t clk_ref,
   output var scas_pkg::scas_in_t in_state,
   output var scas_pkg::scas_speed_t speed_class,
   output logic rate_err,
   output logic mux_reconfig,
   output logic [7:0] rx_ch_en,
   output logic [7:0] tx_ch_en
);
   import scas_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic src_opt;
      logic [2:0] rate_sel;
      logic [PW-1:0] exp_per;
      logic use_ext;
      logic [PW-1:0] int_cnt;
      logic smp_tick;
      logic rate_match;
      logic phase_ok;
      scas_in_t in_state;
      scas_ref_t clk_ref;
      logic rate_err;
      scas_speed_t spd;
      logic spd_chg;
      logic [7:0] rx_en;
      logic [7:0] tx_en;
      logic [DW-1:0] rdata;
   } scas_top_st_t;

   scas_top_st_t st_r;
   scas_top_st_t st_nxt;

   scas_meas_if meas();

   logic wr_ctrl;
   logic wr_exp;
   logic wr_stat;
   logic [PW-1:0] exp_eff;
   logic int_wrap;
   logic err_set;
   logic err_clr;
   scas_speed_t spd_new;

   // ****************************************************************
   // Link clock monitor
   // ****************************************************************
   scas_link_meas u_meas (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .opt_wclk(opt_wclk),
      .opt_spdif_det(opt_spdif_det),
      .mo(meas.src)
   );

   // ****************************************************************
   // Decoding
   // ****************************************************************
   assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   assign wr_exp = reg_wr && (reg_addr == REG_EXP);
   assign wr_stat = reg_wr && (reg_addr == REG_STAT);
   // Too short a period would leave no room for the phase window
   assign exp_eff = (st_r.exp_per < EXP_PER_MIN) ? EXP_PER_MIN : st_r.exp_per;
   assign int_wrap = (st_r.int_cnt >= exp_eff - 12'h001);
   // Fault only while the block sets its own rate
   assign err_set = !st_r.use_ext && meas.lock && !st_r.rate_match;
   assign err_clr = wr_stat && reg_wdata[STAT_ERR_BIT];
   assign spd_new = speed_of(st_r.rate_sel);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;

      if (wr_ctrl) begin
         st_nxt.src_opt = reg_wdata[CTRL_SRC_BIT];
         st_nxt.rate_sel = reg_wdata[CTRL_RATE_LSB +: 3];
      end
      if (wr_exp) begin
         st_nxt.exp_per = reg_wdata[PW-1:0];
      end

      // Internal source never follows the link, optical follows it only
      // while locked, and drops back the cycle after lock goes
      st_nxt.use_ext = st_r.src_opt && meas.lock;

      // Internal divider stands in for the crystal. While slaved it is
      // realigned to each link edge, so a fallback continues in phase.
      st_nxt.int_cnt = int_wrap ? '0 : st_r.int_cnt + 12'h001;
      if (st_r.use_ext && meas.edge_p) begin
         st_nxt.int_cnt = '0;
      end
      st_nxt.smp_tick = st_r.use_ext ? meas.edge_p : int_wrap;

      st_nxt.rate_match = within_tol(meas.period, exp_eff);
      if (meas.edge_p) begin
         st_nxt.phase_ok = (st_r.int_cnt <= PER_TOL) ||
                           (st_r.int_cnt >= exp_eff - PER_TOL);
      end

      // Sync asks for the right rate and, as master, a matching phase;
      // lock alone is not enough for full duplex work
      if (!meas.lock) begin
         st_nxt.in_state = IN_NOLOCK;
      end else if (st_r.rate_match && (st_r.use_ext || st_r.phase_ok)) begin
         st_nxt.in_state = IN_SYNC;
      end else begin
         st_nxt.in_state = IN_LOCK;
      end

      if (!st_nxt.use_ext) begin
         st_nxt.clk_ref = REF_INTERNAL;
      end else if (meas.spdif) begin
         st_nxt.clk_ref = REF_SPDIF;
      end else begin
         st_nxt.clk_ref = REF_OPTICAL;
      end

      // A new fault in the clearing cycle survives the clear
      st_nxt.rate_err = err_set || (st_r.rate_err && !err_clr);

      st_nxt.spd = spd_new;
      st_nxt.spd_chg = (spd_new != st_r.spd);
      st_nxt.tx_en = ch_mask(spd_new);
      if (meas.lock && meas.spdif) begin
         st_nxt.rx_en = MASK_2CH;
      end else begin
         st_nxt.rx_en = ch_mask(spd_new);
      end

      st_nxt.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: begin
               st_nxt.rdata[CTRL_SRC_BIT] = st_r.src_opt;
               st_nxt.rdata[CTRL_RATE_LSB +: 3] = st_r.rate_sel;
            end
            REG_EXP: st_nxt.rdata[PW-1:0] = st_r.exp_per;
            REG_STAT: begin
               st_nxt.rdata[STAT_IN_LSB +: 2] = st_r.in_state;
               st_nxt.rdata[STAT_REF_LSB +: 2] = st_r.clk_ref;
               st_nxt.rdata[STAT_SPD_LSB +: 2] = st_r.spd;
               st_nxt.rdata[STAT_ERR_BIT] = st_r.rate_err;
               st_nxt.rdata[STAT_CHG_BIT] = st_r.spd_chg;
            end
            REG_MEAS: st_nxt.rdata[PW-1:0] = meas.period;
            default: st_nxt.rdata = '0;
         endcase
      end

      if (sys_rst) begin
         st_nxt = '0;
         st_nxt.exp_per = EXP_PER_RST;
         st_nxt.rx_en = MASK_8CH;
         st_nxt.tx_en = MASK_8CH;
      end
   end

   always_ff @(posedge core_clk) begin
      st_r <= st_nxt;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata = st_r.rdata;
   assign smp_tick = st_r.smp_tick;
   assign clk_ref = st_r.clk_ref;
   assign in_state = st_r.in_state;
   assign speed_class = st_r.spd;
   assign rate_err = st_r.rate_err;
   assign mux_reconfig = st_r.spd_chg;
   assign rx_ch_en = st_r.rx_en;
   assign tx_ch_en = st_r.tx_en;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_watch_input_lock: assert property (
      $rose(meas.lock) |=> st_r.in_state != IN_NOLOCK)
      else $error("input lock not reported");

   a_switch_on_lock: assert property (
      (st_r.src_opt && meas.lock) |=> st_r.use_ext)
      else $error("no switch to recovered clock");

   a_ext_has_cause: assert property (
      st_r.use_ext |-> $past(st_r.src_opt) && $past(meas.lock))
      else $error("recovered clock used without cause");

   a_fallback_on_loss: assert property (
      $fell(meas.lock) |=> !st_r.use_ext ##1 (st_r.smp_tick == $past(int_wrap)))
      else $error("no fallback to internal clock");

   a_internal_holds: assert property (
      !st_r.src_opt |=> !st_r.use_ext && st_r.clk_ref == REF_INTERNAL)
      else $error("internal source switched away");

   a_nolock_report: assert property (
      !meas.lock |=> st_r.in_state == IN_NOLOCK)
      else $error("lock shown without lock");

   a_ref_matches_use: assert property (
      st_r.use_ext == (st_r.clk_ref != REF_INTERNAL))
      else $error("reported reference disagrees");

   a_spdif_ref: assert property (
      (st_r.src_opt && meas.lock && meas.spdif) |=> st_r.clk_ref == REF_SPDIF)
      else $error("SPDIF reference not shown");

   a_sync_needs_rate: assert property (
      st_r.in_state == IN_SYNC |-> $past(st_r.rate_match) && $past(meas.lock))
      else $error("sync shown at another rate");

   a_rate_err_set: assert property (
      err_set |=> st_r.rate_err)
      else $error("rate error missed");

   a_rate_err_clear: assert property (
      (st_r.rate_err && err_clr && !err_set) |=> !st_r.rate_err)
      else $error("rate error not cleared");

   a_double_four_ch: assert property (
      st_r.spd == SPD_DOUBLE |-> st_r.tx_en == MASK_4CH)
      else $error("double speed channel mask wrong");

   a_quad_two_ch: assert property (
      st_r.spd == SPD_QUAD |-> st_r.tx_en == MASK_2CH && st_r.rx_en == MASK_2CH)
      else $error("quad speed channel mask wrong");

   a_spdif_slots: assert property (
      (meas.lock && meas.spdif) |=> st_r.rx_en == MASK_2CH)
      else $error("SPDIF not in first two slots");

   a_rx_double: assert property (
      (st_r.spd == SPD_DOUBLE && !$past(meas.spdif)) |-> st_r.rx_en == MASK_4CH)
      else $error("double speed receive mask wrong");

   a_class_change: assert property (
      st_r.spd_chg == $changed(st_r.spd))
      else $error("speed change pulse misplaced");

   // ****************************************************************
   // Status read-back, tick source and link bookkeeping checks
   // ****************************************************************
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside a read cycle");

   a_stat_read_state: assert property (
      ($past(reg_rd) && $past(reg_addr) == REG_STAT) |->
         reg_rdata[STAT_IN_LSB +: 2] == $past(st_r.in_state))
      else $error("status read shows wrong input state");

   a_stat_read_ref: assert property (
      ($past(reg_rd) && $past(reg_addr) == REG_STAT) |->
         reg_rdata[STAT_REF_LSB +: 2] == $past(st_r.clk_ref))
      else $error("status read shows wrong reference");

   a_stat_read_err: assert property (
      ($past(reg_rd) && $past(reg_addr) == REG_STAT) |->
         reg_rdata[STAT_ERR_BIT] == $past(st_r.rate_err))
      else $error("status read shows wrong rate error");

   a_stat_read_speed: assert property (
      ($past(reg_rd) && $past(reg_addr) == REG_STAT) |->
         reg_rdata[STAT_SPD_LSB +: 2] == $past(st_r.spd))
      else $error("status read shows wrong speed class");

   a_tick_follows_link: assert property (
      (st_r.use_ext && meas.edge_p) |=> st_r.smp_tick)
      else $error("link edge gave no sample tick");

   a_no_stray_tick: assert property (
      (st_r.use_ext && !meas.edge_p) |=> !st_r.smp_tick)
      else $error("sample tick without link edge");

   a_tick_from_divider: assert property (
      (!st_r.use_ext && int_wrap) |=> st_r.smp_tick)
      else $error("divider wrap gave no sample tick");

   a_single_eight_ch: assert property (
      st_r.spd == SPD_SINGLE |-> st_r.tx_en == MASK_8CH)
      else $error("single speed channel mask wrong");

   a_sync_phase_master: assert property (
      (st_r.in_state == IN_SYNC && !$past(st_r.use_ext)) |-> $past(st_r.phase_ok))
      else $error("sync shown as master without phase match");

   a_lock_not_sync: assert property (
      (meas.lock && !st_r.rate_match) |=> st_r.in_state == IN_LOCK)
      else $error("other-rate input not shown as lock");

   a_optical_ref: assert property (
      (st_r.src_opt && meas.lock && !meas.spdif) |=> st_r.clk_ref == REF_OPTICAL)
      else $error("optical reference not shown");

   a_err_sticky: assert property (
      (st_r.rate_err && !err_clr) |=> st_r.rate_err)
      else $error("rate error dropped without clear");

   a_no_err_slaved: assert property (
      st_r.use_ext |=> !$rose(st_r.rate_err))
      else $error("rate error raised while slaved");

   a_period_after_edge: assert property (
      meas.period_vld == $past(meas.edge_p))
      else $error("period strobe not after link edge");

   c_go_external: cover property ($rose(st_r.use_ext));
   c_fallback: cover property ($fell(st_r.use_ext));
   c_sync_seen: cover property (st_r.in_state == IN_SYNC);
   c_rate_fault: cover property ($rose(st_r.rate_err));
   c_quad_speed: cover property (st_r.spd_chg && st_r.spd == SPD_QUAD);

endmodule : scas_top
`default_nettype wire

// File: sim/scas_opt_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Far-end optical unit
// ****************************************************************
module scas_opt_partner (
   input wire logic run,
   input wire logic off_rate,
   input wire logic fmt_spdif,
   output logic opt_wclk,
   output logic opt_spdif_det
);
   // Word clock stands low between streams; off_rate breaks the
   // same-rate duty of the far unit, only when the bench asks for it
   initial begin
      opt_wclk = 1'b0;
      #37;
      forever begin
         if (run) begin
            #(off_rate ? 150 : 100) opt_wclk = ~opt_wclk;
         end else begin
            opt_wclk = 1'b0;
            @(posedge run);
         end
      end
   end

   assign opt_spdif_det = fmt_spdif & run;
endmodule : scas_opt_partner
`default_nettype wire

// File: sim/scas_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module scas_top_bench;
   import scas_pkg::*;
   // ****************************************************************
   // Stimulus and wiring
   // ****************************************************************
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [AW-1:0] reg_addr = 8'h00;
   logic [DW-1:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic run = 1'b0;
   logic off_rate = 1'b0;
   logic fmt_spdif = 1'b0;
   logic opt_wclk;
   logic opt_spdif_det;
   logic [DW-1:0] reg_rdata;
   logic smp_tick;
   scas_ref_t clk_ref;
   scas_in_t in_state;
   scas_speed_t speed_class;
   logic rate_err;
   logic mux_reconfig;
   logic [7:0] rx_ch_en;
   logic [7:0] tx_ch_en;
   int err_total = 0;
   int checks = 0;

   always #12.5 core_clk = ~core_clk;

   scas_opt_partner i_far (.run(run), .off_rate(off_rate), .fmt_spdif(fmt_spdif),
      .opt_wclk(opt_wclk), .opt_spdif_det(opt_spdif_det));

   scas_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .opt_wclk(opt_wclk),
      .opt_spdif_det(opt_spdif_det), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_tick(smp_tick),
      .clk_ref(clk_ref), .in_state(in_state), .speed_class(speed_class),
      .rate_err(rate_err), .mux_reconfig(mux_reconfig), .rx_ch_en(rx_ch_en),
      .tx_ch_en(tx_ch_en));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // Counts tick pulses; each stands one cycle, so sample every cycle
   task automatic ticks(output int n);
      n = 0;
      repeat (80) begin
         cyc(1);
         if (smp_tick === 1'b1) n++;
      end
   endtask : ticks

   task automatic done(input string name);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask : done

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      logic [DW-1:0] d;
      chk("clk_ref", 32'(REF_INTERNAL), 32'(clk_ref));
      chk("in_state", 32'(IN_NOLOCK), 32'(in_state));
      chk("speed_class", 32'(SPD_SINGLE), 32'(speed_class));
      chk("tx_ch_en", 32'(MASK_8CH), 32'(tx_ch_en));
      rd(REG_EXP, d);
      chk("exp reset", 32'(EXP_PER_RST), d);
      wr(8'h10, 32'hFFFFFFFF);
      rd(REG_CTRL, d);
      chk("ctrl after stray write", 32'h0, d);
      rd(8'h10, d);
      chk("unmapped read", 32'h0, d);
      done("reset");
   endtask : t_reset

   task automatic t_internal();
      run <= 1'b1;
      for (int n = 0; n < 300 && in_state === IN_NOLOCK; n++) cyc(1);
      chk("in_state locked", 32'h1, 32'(in_state !== IN_NOLOCK));
      cyc(100);
      chk("clk_ref internal", 32'(REF_INTERNAL), 32'(clk_ref));
      run <= 1'b0;
      cyc(400);
      chk("in_state lost", 32'(IN_NOLOCK), 32'(in_state));
      done("internal");
   endtask : t_internal

   task automatic t_mismatch();
      logic [DW-1:0] d;
      off_rate <= 1'b1;
      run <= 1'b1;
      for (int n = 0; n < 400 && rate_err !== 1'b1; n++) cyc(1);
      chk("rate_err", 32'h1, 32'(rate_err));
      chk("lock without sync", 32'(IN_LOCK), 32'(in_state));
      wr(REG_STAT, 32'h40);
      rd(REG_STAT, d);
      chk("rate_err held", 32'h1, 32'(d[STAT_ERR_BIT]));
      run <= 1'b0;
      off_rate <= 1'b0;
      cyc(400);
      wr(REG_STAT, 32'h40);
      rd(REG_STAT, d);
      chk("rate_err cleared", 32'h0, 32'(d[STAT_ERR_BIT]));
      done("mismatch");
   endtask : t_mismatch

   task automatic t_optical();
      logic [DW-1:0] d;
      int n;
      wr(REG_CTRL, 32'h1);
      run <= 1'b1;
      for (int k = 0; k < 300 && clk_ref !== REF_OPTICAL; k++) cyc(1);
      chk("clk_ref optical", 32'(REF_OPTICAL), 32'(clk_ref));
      for (int k = 0; k < 100 && in_state !== IN_SYNC; k++) cyc(1);
      chk("in_state sync", 32'(IN_SYNC), 32'(in_state));
      ticks(n);
      chk("ticks from link", 32'h1, 32'(n >= 9 && n <= 11));
      rd(REG_MEAS, d);
      chk("measured period", 32'h1, 32'(d >= 32'h7 && d <= 32'h9));
      run <= 1'b0;
      for (int k = 0; k < 400 && clk_ref !== REF_INTERNAL; k++) cyc(1);
      chk("clk_ref fallback", 32'(REF_INTERNAL), 32'(clk_ref));
      ticks(n);
      chk("ticks after fallback", 32'h1, 32'(n >= 9 && n <= 11));
      done("optical");
   endtask : t_optical

   task automatic t_spdif();
      fmt_spdif <= 1'b1;
      run <= 1'b1;
      for (int k = 0; k < 300 && clk_ref !== REF_SPDIF; k++) cyc(1);
      chk("clk_ref spdif", 32'(REF_SPDIF), 32'(clk_ref));
      chk("rx_ch_en spdif", 32'(MASK_2CH), 32'(rx_ch_en));
      chk("tx_ch_en spdif", 32'(MASK_8CH), 32'(tx_ch_en));
      run <= 1'b0;
      fmt_spdif <= 1'b0;
      wr(REG_CTRL, 32'h0);
      cyc(400);
      done("spdif");
   endtask : t_spdif

   // Walks every rate code, then back to the first, so both directions change class
   task automatic t_speed();
      scas_speed_t prev;
      scas_speed_t want;
      logic [2:0] r;
      logic [7:0] m;
      int seen;
      prev = SPD_SINGLE;
      for (int i = 0; i < 9; i++) begin
         r = 3'(i);
         want = (r >= RATE_QS_MIN) ? SPD_QUAD : (r >= RATE_DS_MIN) ? SPD_DOUBLE : SPD_SINGLE;
         m = (want == SPD_QUAD) ? MASK_2CH : (want == SPD_DOUBLE) ? MASK_4CH : MASK_8CH;
         wr(REG_CTRL, {28'h0, r, 1'b0});
         seen = 0;
         repeat (4) begin
            #1;
            if (mux_reconfig === 1'b1) seen++;
            @(posedge core_clk);
         end
         #1;
         chk("mux_reconfig pulses", 32'(want != prev), 32'(seen));
         chk("speed_class", 32'(want), 32'(speed_class));
         chk("tx_ch_en", 32'(m), 32'(tx_ch_en));
         chk("rx_ch_en", 32'(m), 32'(rx_ch_en));
         prev = want;
      end
      done("speed");
   endtask : t_speed

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      cyc(1);
      t_reset();
      t_internal();
      t_mismatch();
      t_optical();
      t_spdif();
      t_speed();
      tally_and_finish();
   end

   // Whole run is near 2000 cycles, so this leaves wide margin
   initial begin
      #500000;
      err_total++;
      tally_and_finish();
   end
endmodule : scas_top_bench
`default_nettype wire
